// File: hdl/timing_port_defs.svh
`ifndef TIMING_PORT_DEFS_SVH
`define TIMING_PORT_DEFS_SVH

`define STYLE_BOOT 3'h1
`define STYLE_MUX 3'h2
`define STYLE_SEP 3'h3
`define STYLE_RW 3'h4
`define STYLE_SERIAL 3'h5

`define REG_ID 7'h00
`define REG_IRQ_STAT 7'h01
`define REG_IRQ_MASK 7'h02
`define REG_MODE 7'h03
`define REG_STATUS 7'h04

`define BOOT_WAIT_CYC 4'h6
`define SCLK_HALF_CYC 4'h4

`endif

// File: hdl/timing_port_device.sv
`include "timing_port_defs.svh"
`default_nettype none
module timing_port_device
  import timing_port_pkg::*;
#(
  parameter int unsigned DEPTH = 128,
  parameter logic [7:0] ID_CODE = 8'h5a  // Arbitrary identity value
) (
  input wire logic clock,
  input wire logic reset,
  timing_port_if.dev bus,
  input wire logic [7:0] event_in,
  input wire logic [7:0] status_in,
  output logic primary_secondary,
  output logic boot_done
);

  logic clr;
  logic init_r;
  style_t style_r;
  logic ale_q;
  logic [6:0] addr_r;
  logic served_r;
  logic ready_r;
  logic [7:0] ad_r;
  logic ad_oe_r;
  logic irq_r;
  logic [7:0] mem [DEPTH];
  logic [7:0] stat_r;
  logic [7:0] mask_r;
  logic ps_r;
  logic [3:0] cnt_r;
  logic [6:0] sin_r;
  logic [6:0] ser_addr_r;
  logic ser_rd_r;
  logic [7:0] sout_r;
  boot_state_t bst_r;
  logic [6:0] baddr_r;
  logic [3:0] bwait_r;
  logic [6:0] addr_d_r;
  logic addr_oe_r;
  logic cs_d_r;
  logic boot_done_r;
  logic is_par;
  logic sel;
  logic rd_req;
  logic wr_req;
  logic par_go;
  logic ser_go;
  logic boot_wr;
  logic serial_in;
  logic [6:0] eff_addr;
  logic wen;
  logic [6:0] waddr;
  logic [7:0] wdata;

  function automatic logic [7:0] rd_val(input logic [6:0] a);
    case (a)
      `REG_ID: rd_val = ID_CODE;
      `REG_IRQ_STAT: rd_val = stat_r;
      `REG_IRQ_MASK: rd_val = mask_r;
      `REG_MODE: rd_val = {6'h00, boot_done_r, ps_r};
      `REG_STATUS: rd_val = status_in;
      default: rd_val = mem[a];
    endcase
  endfunction : rd_val

  assign clr = !bus.master_reset_n;
  assign serial_in = bus.addr[0];
  assign is_par = (style_r == `STYLE_MUX) || (style_r == `STYLE_SEP) || (style_r == `STYLE_RW);
  assign sel = !bus.port_select_n && (style_r != `STYLE_BOOT) && !init_r;
  assign eff_addr = (style_r == `STYLE_MUX) ? addr_r : bus.addr;
  assign par_go = is_par && sel && !served_r && (rd_req || wr_req);
  assign ser_go = (style_r == `STYLE_SERIAL) && sel && bus.ale && !ale_q;
  assign boot_wr = (bst_r == B_RUN) && (bwait_r == `BOOT_WAIT_CYC - 4'h1);

  always_comb begin
    if (style_r == `STYLE_RW) begin
      // Read strobe is the data strobe, write strobe carries direction
      rd_req = !bus.read_strobe_n && bus.write_strobe_n;
      wr_req = !bus.read_strobe_n && !bus.write_strobe_n;
    end else begin
      rd_req = !bus.read_strobe_n;
      wr_req = !bus.write_strobe_n;
    end
  end

  always_comb begin
    wen = 1'b0;
    waddr = eff_addr;
    wdata = bus.ad;
    if (par_go && wr_req) begin
      wen = 1'b1;
    end
    if (ser_go && (cnt_r == 4'hf) && !ser_rd_r) begin
      wen = 1'b1;
      waddr = ser_addr_r;
      wdata = {sin_r, serial_in};
    end
    if (boot_wr) begin
      wen = 1'b1;
      waddr = baddr_r;
    end
  end

  // Style is caught on the first clock after either reset lets go
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      init_r <= 1'b1;
      style_r <= 3'h0;
      ale_q <= 1'b0;
    end else begin
      init_r <= clr;
      ale_q <= bus.ale;
      if (init_r || clr) begin
        style_r <= bus.host_style_select;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      addr_r <= 7'h00;
    end else if (clr) begin
      addr_r <= 7'h00;
    end else if ((style_r == `STYLE_MUX) && ale_q && !bus.ale) begin
      addr_r <= bus.ad[6:0];
    end
  end

  // One answer per strobe; a held strobe is not served twice
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      served_r <= 1'b0;
      ready_r <= 1'b0;
      ad_r <= 8'h00;
      ad_oe_r <= 1'b0;
    end else if (clr || !sel) begin
      served_r <= 1'b0;
      ready_r <= 1'b0;
      ad_oe_r <= 1'b0;
    end else if (is_par) begin
      if (!(rd_req || wr_req)) begin
        served_r <= 1'b0;
        ready_r <= 1'b0;
        ad_oe_r <= 1'b0;
      end else if (!served_r) begin
        served_r <= 1'b1;
        ready_r <= 1'b1;
        if (rd_req) begin
          ad_r <= rd_val(eff_addr);
          ad_oe_r <= 1'b1;
        end
      end
    end else begin
      ad_r <= {7'h00, sout_r[7]};
      ad_oe_r <= ser_rd_r && cnt_r[3];
    end
  end

  // Serial frame: read flag, 7 address bits, 8 data bits, MSB first
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt_r <= 4'h0;
      sin_r <= 7'h00;
      ser_addr_r <= 7'h00;
      ser_rd_r <= 1'b0;
      sout_r <= 8'h00;
    end else if (clr || !sel || (style_r != `STYLE_SERIAL)) begin
      cnt_r <= 4'h0;
      ser_rd_r <= 1'b0;
    end else if (ser_go) begin
      sin_r <= {sin_r[5:0], serial_in};
      cnt_r <= cnt_r + 4'h1;
      if (cnt_r == 4'h7) begin
        ser_rd_r <= sin_r[6];
        ser_addr_r <= {sin_r[5:0], serial_in};
        sout_r <= rd_val({sin_r[5:0], serial_in});
      end else begin
        sout_r <= {sout_r[6:0], 1'b0};
      end
    end
  end

  // Boot copy: one byte per wait period, device owns address and select
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      bst_r <= B_IDLE;
      baddr_r <= 7'h00;
      bwait_r <= 4'h0;
      addr_d_r <= 7'h00;
      addr_oe_r <= 1'b0;
      cs_d_r <= 1'b1;
      boot_done_r <= 1'b0;
    end else if (clr) begin
      bst_r <= B_IDLE;
      baddr_r <= 7'h00;
      bwait_r <= 4'h0;
      addr_oe_r <= 1'b0;
      cs_d_r <= 1'b1;
      boot_done_r <= 1'b0;
    end else begin
      case (bst_r)
        B_IDLE: begin
          if (!init_r && (style_r == `STYLE_BOOT)) begin
            bst_r <= B_RUN;
            addr_oe_r <= 1'b1;
            cs_d_r <= 1'b0;
            addr_d_r <= 7'h00;
          end
        end
        B_RUN: begin
          addr_d_r <= baddr_r;
          if (boot_wr) begin
            bwait_r <= 4'h0;
            if (baddr_r == 7'(DEPTH - 1)) begin
              bst_r <= B_DONE;
              addr_oe_r <= 1'b0;
              cs_d_r <= 1'b1;
              boot_done_r <= 1'b1;
            end else begin
              baddr_r <= baddr_r + 7'h01;
            end
          end else begin
            bwait_r <= bwait_r + 4'h1;
          end
        end
        B_DONE: bst_r <= B_DONE;
        default: bst_r <= B_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= 8'h00;
      end
    end else if (clr) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= 8'h00;
      end
    end else if (wen) begin
      mem[waddr] <= wdata;
    end
  end

  // Write-one-to-clear; a new event in the same cycle survives the clear
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      stat_r <= 8'h00;
      mask_r <= 8'h00;
      irq_r <= 1'b0;
    end else if (clr) begin
      stat_r <= 8'h00;
      mask_r <= 8'h00;
      irq_r <= 1'b0;
    end else begin
      stat_r <= (stat_r & ~((wen && (waddr == `REG_IRQ_STAT)) ? wdata : 8'h00)) | event_in;
      if (wen && (waddr == `REG_IRQ_MASK)) begin
        mask_r <= wdata;
      end
      irq_r <= |(stat_r & mask_r);
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ps_r <= 1'b0;
    end else if (init_r || clr) begin
      ps_r <= bus.primary_secondary_select;
    end else if (wen && (waddr == `REG_MODE)) begin
      ps_r <= wdata[0];
    end
  end

  assign bus.ready = ready_r;
  assign bus.irq_out = irq_r;
  assign bus.ad_d = ad_r;
  assign bus.ad_d_oe = ad_oe_r;
  assign bus.addr_d = addr_d_r;
  assign bus.addr_d_oe = addr_oe_r;
  assign bus.cs_n_d = cs_d_r;
  assign primary_secondary = ps_r;
  assign boot_done = boot_done_r;

endmodule : timing_port_device
`default_nettype wire

// File: hdl/timing_port_host.sv
`include "timing_port_defs.svh"
`default_nettype none
module timing_port_host
  import timing_port_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  timing_port_if.host bus,
  input wire logic [2:0] host_style,
  input wire logic master_reset_req,
  input wire logic primary_secondary_pin,
  input wire logic req,
  input wire logic req_write,
  input wire logic [6:0] req_addr,
  input wire logic [7:0] req_wdata,
  input wire logic [7:0] boot_data,
  output logic busy,
  output logic done,
  output logic [7:0] rdata,
  output logic irq,
  output logic [6:0] boot_addr
);

  host_state_t st_r;
  style_t style_r;
  logic mrst_n_r;
  logic ps_r;
  logic irq_r;
  logic [6:0] baddr_r;
  logic cs_n_r;
  logic wr_n_r;
  logic rd_n_r;
  logic ale_r;
  logic [6:0] addr_r;
  logic [7:0] ad_r;
  logic ad_oe_r;
  logic busy_r;
  logic done_r;
  logic [7:0] rdata_r;
  logic [3:0] div_r;
  logic [3:0] bit_r;
  logic [14:0] tx_r;
  logic [7:0] rx_r;
  logic write_r;
  logic tick;

  assign tick = (div_r == `SCLK_HALF_CYC - 4'h1);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      style_r <= 3'h0;
      mrst_n_r <= 1'b0;
      ps_r <= 1'b0;
      irq_r <= 1'b0;
      baddr_r <= 7'h00;
    end else begin
      style_r <= host_style;
      mrst_n_r <= !master_reset_req;
      ps_r <= primary_secondary_pin;
      irq_r <= bus.irq_out;
      baddr_r <= bus.addr;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_r <= H_IDLE;
      cs_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      ale_r <= 1'b0;
      addr_r <= 7'h00;
      ad_r <= 8'h00;
      ad_oe_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      rdata_r <= 8'h00;
      div_r <= 4'h0;
      bit_r <= 4'h0;
      tx_r <= 15'h0000;
      rx_r <= 8'h00;
      write_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (st_r)
        H_IDLE: begin
          if (style_r == `STYLE_BOOT) begin
            // Act as the boot memory while the device selects us
            ad_r <= boot_data;
            ad_oe_r <= !bus.port_select_n;
          end else if (req) begin
            busy_r <= 1'b1;
            write_r <= req_write;
            tx_r <= {req_addr, req_wdata};
            cs_n_r <= 1'b0;
            if (style_r == `STYLE_SERIAL) begin
              addr_r <= {6'h00, !req_write};
              div_r <= 4'h0;
              bit_r <= 4'h0;
              st_r <= H_SER;
            end else begin
              addr_r <= req_addr;
              ad_r <= {1'b0, req_addr};
              ad_oe_r <= (style_r == `STYLE_MUX);
              ale_r <= 1'b1;
              wr_n_r <= !((style_r == `STYLE_RW) && req_write);
              st_r <= H_ADDR;
            end
          end
        end
        H_ADDR: begin
          ale_r <= 1'b0;
          st_r <= H_LATCH;
        end
        H_LATCH: begin
          ad_r <= tx_r[7:0];
          ad_oe_r <= write_r;
          if ((style_r == `STYLE_RW) || !write_r) begin
            rd_n_r <= 1'b0;
          end else begin
            wr_n_r <= 1'b0;
          end
          st_r <= H_STB;
        end
        H_STB: begin
          if (bus.ready) begin
            if (!write_r) begin
              rdata_r <= bus.ad;
            end
            st_r <= H_END;
          end
        end
        H_SER: begin
          if (tick) begin
            div_r <= 4'h0;
            if (!ale_r) begin
              ale_r <= 1'b1;
              if (bit_r[3]) begin
                rx_r <= {rx_r[6:0], bus.ad[0]};
              end
            end else begin
              ale_r <= 1'b0;
              bit_r <= bit_r + 4'h1;
              addr_r[0] <= tx_r[14];
              tx_r <= {tx_r[13:0], 1'b0};
              if (bit_r == 4'hf) begin
                st_r <= H_END;
              end
            end
          end else begin
            div_r <= div_r + 4'h1;
          end
        end
        H_END: begin
          cs_n_r <= 1'b1;
          wr_n_r <= 1'b1;
          rd_n_r <= 1'b1;
          ale_r <= 1'b0;
          ad_oe_r <= 1'b0;
          busy_r <= 1'b0;
          done_r <= 1'b1;
          if ((style_r == `STYLE_SERIAL) && !write_r) begin
            rdata_r <= rx_r;
          end
          st_r <= H_IDLE;
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

  assign bus.host_style_select = style_r;
  assign bus.master_reset_n = mrst_n_r;
  assign bus.primary_secondary_select = ps_r;
  assign bus.write_strobe_n = wr_n_r;
  assign bus.read_strobe_n = rd_n_r;
  assign bus.ale = ale_r;
  assign bus.addr_h = addr_r;
  assign bus.cs_n_h = cs_n_r;
  assign bus.ad_h = ad_r;
  assign bus.ad_h_oe = ad_oe_r;
  assign busy = busy_r;
  assign done = done_r;
  assign rdata = rdata_r;
  assign irq = irq_r;
  assign boot_addr = baddr_r;

endmodule : timing_port_host
`default_nettype wire

// File: hdl/timing_port_if.sv
`default_nettype none
interface timing_port_if;
  logic [2:0] host_style_select;
  logic master_reset_n;
  logic primary_secondary_select;
  logic write_strobe_n;
  logic read_strobe_n;
  logic ale;
  logic ready;
  logic irq_out;
  logic [6:0] addr_h;
  logic [6:0] addr_d;
  logic addr_d_oe;
  logic cs_n_h;
  logic cs_n_d;
  logic [7:0] ad_h;
  logic ad_h_oe;
  logic [7:0] ad_d;
  logic ad_d_oe;
  logic [6:0] addr;
  logic port_select_n;
  logic [7:0] ad;

  // Shared wires resolved from the enables; device wins in boot mode
  assign addr = addr_d_oe ? addr_d : addr_h;
  assign port_select_n = addr_d_oe ? cs_n_d : cs_n_h;
  assign ad = ad_d_oe ? ad_d : (ad_h_oe ? ad_h : 8'h00);

  modport dev (
    input host_style_select, master_reset_n, primary_secondary_select,
    input write_strobe_n, read_strobe_n, ale, addr, port_select_n, ad,
    output ready, irq_out, addr_d, addr_d_oe, cs_n_d, ad_d, ad_d_oe
  );
  modport host (
    output host_style_select, master_reset_n, primary_secondary_select,
    output write_strobe_n, read_strobe_n, ale, addr_h, cs_n_h, ad_h, ad_h_oe,
    input ready, irq_out, addr, port_select_n, ad
  );
endinterface : timing_port_if
`default_nettype wire

// File: hdl/timing_port_pkg.sv
`default_nettype none
package timing_port_pkg;
  typedef logic [2:0] style_t;
  typedef enum logic [1:0] {B_IDLE, B_RUN, B_DONE} boot_state_t;
  typedef enum logic [2:0] {H_IDLE, H_ADDR, H_LATCH, H_STB, H_SER, H_END} host_state_t;
endpackage : timing_port_pkg
`default_nettype wire

// File: testbench/test_timing_source_host_port.sv
`include "timing_port_defs.svh"
`default_nettype none
module test_timing_source_host_port
  import timing_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ID = 8'h3c;  // Arbitrary identity value
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [2:0] host_style = `STYLE_SEP;
  logic master_reset_req = 1'b0;
  logic ps_pin = 1'b0;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic [6:0] req_addr = 7'h00;
  logic [7:0] req_wdata = 8'h00;
  logic [7:0] event_in = 8'h00;
  logic [7:0] status_in = 8'h96;
  logic [7:0] boot_data;
  logic [7:0] rdata;
  logic [6:0] boot_addr;
  logic busy, done, irq, primary_secondary, boot_done;
  int mismatches = 0;
  int n_checks = 0;

  always #4 clock = ~clock;
  // Boot image is a pattern of the address so a stuck address shows
  assign boot_data = {1'b0, boot_addr} ^ 8'h5c;

  timing_port_if bus ();
  timing_port_device #(.ID_CODE(ID)) timing_port_device_inst (.clock(clock), .reset(reset),
    .bus(bus.dev), .event_in(event_in), .status_in(status_in),
    .primary_secondary(primary_secondary), .boot_done(boot_done));
  timing_port_host timing_port_host_inst (.clock(clock), .reset(reset), .bus(bus.host),
    .host_style(host_style), .master_reset_req(master_reset_req),
    .primary_secondary_pin(ps_pin), .req(req), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .boot_data(boot_data), .busy(busy), .done(done), .rdata(rdata),
    .irq(irq), .boot_addr(boot_addr));
  timing_port_monitor timing_port_monitor_inst (.clock(clock), .reset(reset),
    .host_style_select(bus.host_style_select), .master_reset_n(bus.master_reset_n),
    .write_strobe_n(bus.write_strobe_n), .read_strobe_n(bus.read_strobe_n),
    .ready(bus.ready), .irq_out(bus.irq_out), .port_select_n(bus.port_select_n),
    .ad_d_oe(bus.ad_d_oe), .addr_d_oe(bus.addr_d_oe));

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask : check

  task automatic acc(input logic wr, input logic [6:0] a, input logic [7:0] d);
    int i;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    req = 1'b1;
    tick(1);
    req = 1'b0;
    check({7'h0, busy}, 8'h01);
    for (i = 0; i < 400 && done !== 1'b1; i++) tick(1);
    if (done !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t: access never completed", $time);
    end
    check({7'h0, busy}, 8'h00);
  endtask : acc

  task automatic restyle(input logic [2:0] s, input logic pin);
    host_style = s;
    ps_pin = pin;
    master_reset_req = 1'b1;
    tick(3);
    master_reset_req = 1'b0;
    tick(4);
    check({5'h0, bus.host_style_select}, {5'h0, s});
  endtask : restyle

  task automatic t_boot;
    int i;
    restyle(`STYLE_BOOT, 1'b0);
    tick(2);
    check({6'h0, bus.addr_d_oe, bus.port_select_n}, 8'h02);
    for (i = 0; i < 1500 && boot_done !== 1'b1; i++) tick(1);
    check({7'h0, boot_done}, 8'h01);
    check({7'h0, bus.addr_d_oe}, 8'h00);
    // Byte 3 of the image is 5fh and byte 2 is 5eh: mode bit0 and mask bit1 set
    check({7'h0, primary_secondary}, 8'h01);
    event_in = 8'h02;
    tick(1);
    event_in = 8'h00;
    tick(3);
    check({7'h0, irq}, 8'h01);
    $display("boot test done");
  endtask : t_boot

  task automatic t_reset;
    restyle(`STYLE_SEP, 1'b0);
    acc(1'b1, 7'h20, 8'h77);
    acc(1'b1, `REG_IRQ_MASK, 8'hff);
    restyle(`STYLE_SEP, 1'b1);
    acc(1'b0, 7'h20, 8'h00);
    check(rdata, 8'h00);
    acc(1'b0, `REG_IRQ_MASK, 8'h00);
    check(rdata, 8'h00);
    check({7'h0, primary_secondary}, 8'h01);
    $display("master reset test done");
  endtask : t_reset

  task automatic t_parallel(input logic [2:0] s, input logic pin);
    restyle(s, pin);
    acc(1'b1, 7'h10, {5'h0, s} ^ 8'hc3);
    acc(1'b0, 7'h10, 8'h00);
    check(rdata, {5'h0, s} ^ 8'hc3);
    acc(1'b0, `REG_ID, 8'h00);
    check(rdata, ID);
    acc(1'b0, `REG_STATUS, 8'h00);
    check(rdata, status_in);
    acc(1'b0, `REG_MODE, 8'h00);
    check({7'h0, rdata[0]}, {7'h0, pin});
    // One edge after the read ends the device must have let go of the bus
    tick(1);
    check({5'h0, bus.port_select_n, bus.ready, bus.ad_d_oe}, 8'h04);
    acc(1'b1, `REG_MODE, {7'h0, ~pin});
    check({7'h0, primary_secondary}, {7'h0, ~pin});
    $display("parallel style %0d test done", s);
  endtask : t_parallel

  task automatic t_irq;
    acc(1'b1, `REG_IRQ_MASK, 8'h04);
    event_in = 8'h01;
    tick(1);
    event_in = 8'h00;
    tick(3);
    check({7'h0, irq}, 8'h00);
    event_in = 8'h04;
    tick(1);
    event_in = 8'h00;
    tick(3);
    check({7'h0, irq}, 8'h01);
    acc(1'b0, `REG_IRQ_STAT, 8'h00);
    check(rdata, 8'h05);
    acc(1'b1, `REG_IRQ_STAT, 8'h04);
    tick(3);
    check({7'h0, irq}, 8'h00);
    acc(1'b0, `REG_IRQ_STAT, 8'h00);
    check(rdata, 8'h01);
    $display("interrupt test done");
  endtask : t_irq

  task automatic t_serial;
    restyle(`STYLE_SERIAL, 1'b0);
    acc(1'b1, 7'h31, 8'ha6);
    acc(1'b1, 7'h32, 8'h59);
    acc(1'b0, 7'h31, 8'h00);
    check(rdata, 8'ha6);
    acc(1'b0, 7'h32, 8'h00);
    check(rdata, 8'h59);
    $display("serial test done");
  endtask : t_serial

  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (3) @(posedge clock);
    #1;
    reset = 1'b0;
    tick(4);
    t_boot();
    t_reset();
    t_parallel(`STYLE_MUX, 1'b1);
    t_parallel(`STYLE_SEP, 1'b0);
    t_parallel(`STYLE_RW, 1'b1);
    t_irq();
    t_serial();
    print_verdict();
  end

  // The whole run needs under two thousand cycles; this allows about 20000
  initial begin
    #160000;
    mismatches++;
    $display("[FAIL] %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule : test_timing_source_host_port
`default_nettype wire

// File: testbench/timing_port_monitor.sv
`include "timing_port_defs.svh"
`default_nettype none
module timing_port_monitor
  import timing_port_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [2:0] host_style_select,
  input wire logic master_reset_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic ready,
  input wire logic irq_out,
  input wire logic port_select_n,
  input wire logic ad_d_oe,
  input wire logic addr_d_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic par;
  logic stb;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  assign par = host_style_select inside {`STYLE_MUX, `STYLE_SEP, `STYLE_RW};
  // In the read/write-line style only the read strobe marks the data phase
  assign stb = !read_strobe_n || (!write_strobe_n && host_style_select != `STYLE_RW);

  a_ready_needs_select: assert property (port_select_n |=> !ready)
    else $error("ready seen after deselect");
  a_bus_release_idle: assert property (port_select_n && par |=> !ad_d_oe)
    else $error("data bus driven while deselected");
  a_ready_has_cause: assert property (
    $rose(ready) |-> !$past(port_select_n) && $past(stb))
    else $error("ready rose without a selected strobe");
  a_ready_on_time: assert property (
    $rose(stb) && !port_select_n && par && master_reset_n |-> ##[1:2] ready)
    else $error("ready late after strobe");
  a_ready_stands: assert property (ready && !port_select_n && stb |=> ready)
    else $error("ready dropped while strobe held");
  a_read_drives_bus: assert property (
    ready && !read_strobe_n && (host_style_select != `STYLE_RW || write_strobe_n)
    |-> ad_d_oe)
    else $error("read answer not driven");
  a_write_no_drive: assert property (ready && !write_strobe_n |-> !ad_d_oe)
    else $error("bus driven during write");
  a_boot_owns_addr: assert property (addr_d_oe |-> host_style_select == `STYLE_BOOT)
    else $error("address driven outside boot style");
  a_reset_clears: assert property (
    !master_reset_n ##1 !master_reset_n |-> !irq_out && !ready)
    else $error("state kept through master reset");
  a_serial_no_ready: assert property (
    host_style_select == `STYLE_SERIAL && master_reset_n |-> !ready)
    else $error("ready shown in serial style");
endmodule : timing_port_monitor
`default_nettype wire
